// ---- inc/spi_byte_shift_port_map.vh ----
`ifndef SPI_BYTE_SHIFT_PORT_MAP_VH
`define SPI_BYTE_SHIFT_PORT_MAP_VH

// ==========================================
// register offsets, bank 0
`define ADDR_SERIAL_TRANSMIT_BUFFER 8'h29
`define ADDR_SERIAL_RECEIVE_BUFFER  8'h2a
`define ADDR_SERIAL_CONTROL_STATUS  8'h2b

// ==========================================
// control/status field positions
`define CSR_LSB_FIRST  7
`define CSR_OVERRUN    6
`define CSR_COMPLETE   5
`define CSR_TX_EMPTY   4
`define CSR_RX_FULL    3
`define CSR_PHASE      2
`define CSR_POLARITY   1
`define CSR_ENABLE     0

// ==========================================
// reset values
`define RST_TRANSMIT_BUFFER 8'h00
`define RST_RECEIVE_BUFFER  8'h00
`define RST_CONFIG          1'b0

// ==========================================
// sizes
`define DATA_WIDTH    8
`define RX_FIFO_DEPTH 32
`define BIT_COUNT_W   3
`define LAST_BIT      3'h7

`endif

// ---- rtl/byte_fifo.v ----
`timescale 1ns/100ps
`include "spi_byte_shift_port_map.vh"

module byte_fifo #(
	parameter WIDTH = `DATA_WIDTH,
	parameter DEPTH = `RX_FIFO_DEPTH
) (
	// clock and reset
	input  wire             clock_i,
	input  wire             reset_i,
	input  wire             ce_i,
	// fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// drain side
	output reg              out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o
);
	localparam AW = $clog2(DEPTH);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;

	wire push;
	wire load_out;

	// ==========================================
	// control
	assign in_ready_o = (count != DEPTH[AW:0]);
	assign push       = in_valid_i & in_ready_o;
	// output register refills whenever it is free or being taken
	assign load_out   = (count != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

	always @(posedge clock_i) begin
		// storage freezes with the rest of the state
		if (ce_i & push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			wr_ptr      <= {AW{1'b0}};
			rd_ptr      <= {AW{1'b0}};
			count       <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {WIDTH{1'b0}};
		end else if (ce_i) begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (load_out) begin
				out_data_o  <= mem[rd_ptr];
				rd_ptr      <= rd_ptr + 1'b1;
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			if (push & ~load_out) begin
				count <= count + 1'b1;
			end else if (~push & load_out) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ---- rtl/spi_byte_shift_port.v ----
// Overview of operation
// - An 8-bit write-only transmit buffer at bank 0 offset 29h, reset to zero, holds the next byte to send.
// - An 8-bit read-only receive buffer at bank 0 offset 2ah, reset to zero, returns the oldest completed byte not yet read.
// - Control bit 7 clear shifts most significant bit first, set shifts least significant bit first.
// - Status bit 6 sets when a byte arrives before the previous one was read, and clears on a status read.
// - Status bit 5 sets on the eighth sample edge of a byte, and clears on a status read.
// - Status bit 4, transmit empty, reads one after reset and whenever the block is disabled.
// - A write to the transmit buffer while enabled clears transmit empty, which is the block's default event.
// - The transmit-empty event fires only once a written byte has moved into the shifter.
// - Status bit 3 sets when a byte loads into the receive buffer and clears on a receive buffer read.
// - Phase bit 2 clear samples on the leading edge and changes on the trailing, set does the reverse.
// - Polarity bit 1 clear means the serial clock idles low, set means it idles high.
// - Control bit 0 enables the serial function and resets to zero.
`timescale 1ns/100ps
`include "spi_byte_shift_port_map.vh"

module spi_byte_shift_port (
	// clock, reset, enable
	input  wire       clock_i,
	input  wire       reset_i,
	input  wire       ce_i,
	// register port
	input  wire       bank_select_bit_i,
	input  wire [7:0] io_addr_i,
	input  wire       io_wr_i,
	input  wire       io_rd_i,
	input  wire [7:0] io_wdata_i,
	output reg  [7:0] io_rdata_o,
	// serial link
	input  wire       sclk_i,
	input  wire       mosi_i,
	input  wire       ss_n_i,
	output reg        miso_o,
	output wire       miso_oe_n_o,
	// events
	output reg        tx_empty_event_o,
	output reg        complete_event_o
);
	// ==========================================
	// shift helper
	function [7:0] shift_in;
		input [7:0] value;
		input       bit_in;
		input       lsb_first;
		begin
			if (lsb_first) begin
				shift_in = {bit_in, value[7:1]};
			end else begin
				shift_in = {value[6:0], bit_in};
			end
		end
	endfunction

	// ==========================================
	// bit presented on the output pin
	function out_bit;
		input [7:0] value;
		input       lsb_first;
		begin
			if (lsb_first) begin
				out_bit = value[0];
			end else begin
				out_bit = value[7];
			end
		end
	endfunction

	// ==========================================
	// configuration and state
	reg                      cfg_lsb_first;
	reg                      cfg_phase;
	reg                      cfg_polarity;
	reg                      cfg_enable;
	reg                      overrun;
	reg                      complete;
	reg                      tx_full;
	reg                      rx_full;
	reg  [7:0]               tx_buf;
	reg  [7:0]               rx_buf;
	reg  [7:0]               tx_shift;
	reg  [7:0]               rx_shift;
	reg                      shifter_loaded;
	reg  [`BIT_COUNT_W-1:0]  bit_count;

	// pin synchronisers
	reg                      sclk_s1;
	reg                      sclk_s2;
	reg                      sclk_s3;
	reg                      mosi_s1;
	reg                      mosi_s2;
	reg                      ss_n_s1;
	reg                      ss_n_s2;

	// ==========================================
	// address decode
	reg  sel_tx;
	reg  sel_rx;
	reg  sel_csr;

	always @* begin
		sel_tx  = 1'b0;
		sel_rx  = 1'b0;
		sel_csr = 1'b0;
		// the other bank reaches none of these registers
		if (bank_select_bit_i) begin
			sel_tx = 1'b0;
		end else if (io_addr_i == `ADDR_SERIAL_TRANSMIT_BUFFER) begin
			sel_tx = 1'b1;
		end else if (io_addr_i == `ADDR_SERIAL_RECEIVE_BUFFER) begin
			sel_rx = 1'b1;
		end else if (io_addr_i == `ADDR_SERIAL_CONTROL_STATUS) begin
			sel_csr = 1'b1;
		end
	end

	wire wr_tx  = io_wr_i & sel_tx;
	wire wr_csr = io_wr_i & sel_csr;
	wire rd_rx  = io_rd_i & sel_rx;
	wire rd_csr = io_rd_i & sel_csr;

	// ==========================================
	// link edge detection
	wire link_active  = cfg_enable & ~ss_n_s2;
	// third sclk stage only feeds the edge compare; miso settles about four
	// clocks after a change edge, so an sclk half period needs more than four
	// fold polarity so the leading edge is always a rise
	wire clk_now      = sclk_s2 ^ cfg_polarity;
	wire clk_before   = sclk_s3 ^ cfg_polarity;
	wire edge_lead    = clk_now & ~clk_before;
	wire edge_trail   = ~clk_now & clk_before;
	wire sample_edge  = link_active & (cfg_phase ? edge_trail : edge_lead);
	wire change_edge  = link_active & (cfg_phase ? edge_lead : edge_trail);
	wire last_sample  = sample_edge & (bit_count == `LAST_BIT);
	wire [7:0] rx_next = shift_in(rx_shift, mosi_s2, cfg_lsb_first);

	// the first bit is already presented at load, so a change edge only
	// advances between samples; a stray trailing edge cannot skip a bit
	wire advance_tx   = change_edge & (bit_count != {`BIT_COUNT_W{1'b0}});
	wire move_to_shift = cfg_enable & tx_full & ~shifter_loaded & ~advance_tx;

	// ==========================================
	// receive path buffer
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire       fifo_out_ready = ~rx_full | rd_rx;
	wire       rx_load        = fifo_out_valid & fifo_out_ready;
	// the fifo soaks up bursts so a slow reader loses nothing until it fills
	// a full buffer is the back-pressure: the byte is lost and flagged
	wire       rx_lost        = last_sample & ~fifo_in_ready;

	byte_fifo #(
		.WIDTH (`DATA_WIDTH),
		.DEPTH (`RX_FIFO_DEPTH)
	) rx_fifo (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.ce_i        (ce_i),
		.in_valid_i  (last_sample),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (rx_next),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data)
	);

	// ==========================================
	// synchronisers
	// select resets high so no false frame start follows reset
	always @(posedge clock_i) begin
		if (reset_i) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			ss_n_s1 <= 1'b1;
			ss_n_s2 <= 1'b1;
		end else if (ce_i) begin
			sclk_s1 <= sclk_i;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			mosi_s1 <= mosi_i;
			mosi_s2 <= mosi_s1;
			ss_n_s1 <= ss_n_i;
			ss_n_s2 <= ss_n_s1;
		end
	end

	// ==========================================
	// configuration register
	always @(posedge clock_i) begin
		if (reset_i) begin
			cfg_lsb_first <= `RST_CONFIG;
			cfg_phase     <= `RST_CONFIG;
			cfg_polarity  <= `RST_CONFIG;
			cfg_enable    <= `RST_CONFIG;
		end else if (ce_i & wr_csr) begin
			// status bits of the written byte are dropped
			// order, phase and polarity are only safe to change while disabled
			cfg_lsb_first <= io_wdata_i[`CSR_LSB_FIRST];
			cfg_phase     <= io_wdata_i[`CSR_PHASE];
			cfg_polarity  <= io_wdata_i[`CSR_POLARITY];
			cfg_enable    <= io_wdata_i[`CSR_ENABLE];
		end
	end

	// ==========================================
	// transmit buffer and shifter
	always @(posedge clock_i) begin
		if (reset_i) begin
			tx_buf         <= `RST_TRANSMIT_BUFFER;
			tx_full        <= 1'b0;
			tx_shift       <= 8'h00;
			shifter_loaded <= 1'b0;
			bit_count      <= {`BIT_COUNT_W{1'b0}};
			miso_o         <= 1'b0;
		end else if (ce_i) begin
			// a write while a byte waits replaces it; the old byte is not sent
			if (wr_tx) begin
				tx_buf <= io_wdata_i;
			end
			if (~cfg_enable) begin
				// disabling drops any byte in flight
				tx_full        <= 1'b0;
				shifter_loaded <= 1'b0;
				bit_count      <= {`BIT_COUNT_W{1'b0}};
			end else begin
				if (wr_tx) begin
					tx_full <= 1'b1;
				end else if (move_to_shift) begin
					tx_full <= 1'b0;
				end
				if (ss_n_s2) begin
					bit_count <= {`BIT_COUNT_W{1'b0}};
				end else if (sample_edge) begin
					bit_count <= bit_count + 1'b1;
				end
				if (move_to_shift) begin
					tx_shift       <= tx_buf;
					shifter_loaded <= 1'b1;
				end else if (advance_tx) begin
					tx_shift <= shift_in(tx_shift, 1'b0, cfg_lsb_first);
				end
				if (last_sample) begin
					shifter_loaded <= 1'b0;
				end
			end
			if (move_to_shift) begin
				miso_o <= out_bit(tx_buf, cfg_lsb_first);
			end else begin
				miso_o <= out_bit(tx_shift, cfg_lsb_first);
			end
		end
	end

	// drive only while selected and enabled
	assign miso_oe_n_o = ~link_active;

	// ==========================================
	// receive shifter and receive buffer
	always @(posedge clock_i) begin
		if (reset_i) begin
			rx_shift <= 8'h00;
			rx_buf   <= `RST_RECEIVE_BUFFER;
			rx_full  <= 1'b0;
		end else if (ce_i) begin
			if (sample_edge) begin
				rx_shift <= rx_next;
			end
			if (rx_load) begin
				rx_buf  <= fifo_out_data;
				rx_full <= 1'b1;
			end else if (rd_rx) begin
				rx_full <= 1'b0;
			end
		end
	end

	// ==========================================
	// sticky status; a set in the clearing cycle wins
	// overrun also counts a byte still queued, so loss is seen early
	wire overrun_set = last_sample & (rx_full | fifo_out_valid | rx_lost);

	always @(posedge clock_i) begin
		if (reset_i) begin
			overrun  <= 1'b0;
			complete <= 1'b0;
		end else if (ce_i) begin
			if (overrun_set) begin
				overrun <= 1'b1;
			end else if (rd_csr) begin
				overrun <= 1'b0;
			end
			if (last_sample) begin
				complete <= 1'b1;
			end else if (rd_csr) begin
				complete <= 1'b0;
			end
		end
	end

	// ==========================================
	// event pulses
	// one clock wide; a level would hide back-to-back bytes
	always @(posedge clock_i) begin
		if (reset_i) begin
			tx_empty_event_o <= 1'b0;
			complete_event_o <= 1'b0;
		end else if (ce_i) begin
			tx_empty_event_o <= move_to_shift;
			complete_event_o <= last_sample;
		end
	end

	// ==========================================
	// read data
	wire [7:0] csr_value = {cfg_lsb_first,
	                        overrun,
	                        complete,
	                        ~tx_full | ~cfg_enable,
	                        rx_full,
	                        cfg_phase,
	                        cfg_polarity,
	                        cfg_enable};

	always @(posedge clock_i) begin
		if (reset_i) begin
			io_rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (rd_csr) begin
				io_rdata_o <= csr_value;
			end else if (rd_rx) begin
				io_rdata_o <= rx_buf;
			end else if (io_rd_i & ~bank_select_bit_i) begin
				// transmit buffer and unmapped offsets read as zero;
				// an access to the other bank leaves the last data standing
				io_rdata_o <= 8'h00;
			end
		end
	end
endmodule

// ---- sim/spi_byte_shift_port_monitor.sv ----
`timescale 1ns/100ps

module spi_byte_shift_port_monitor (
	// clock, reset, enable
	input wire       clock_i,
	input wire       reset_i,
	input wire       ce_i,
	// register port
	input wire       bank_select_bit_i,
	input wire [7:0] io_addr_i,
	input wire       io_rd_i,
	input wire [7:0] io_rdata_o,
	// serial link and events
	input wire       ss_n_i,
	input wire       miso_o,
	input wire       miso_oe_n_o,
	input wire       tx_empty_event_o,
	input wire       complete_event_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	wire rd_take  = io_rd_i && ce_i && !bank_select_bit_i;
	wire unmapped = io_addr_i < 8'h29 || io_addr_i > 8'h2b;

	// ==========
	// register port
	a_write_only_zero: assert property (rd_take && io_addr_i == 8'h29 |=> io_rdata_o == 8'h00)
		else $error("transmit buffer read back nonzero");
	a_unmapped_zero: assert property (rd_take && unmapped |=> io_rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	a_other_bank: assert property (io_rd_i && ce_i && bank_select_bit_i |=> $stable(io_rdata_o))
		else $error("bank 1 read changed read data");
	a_rdata_hold: assert property (!rd_take |=> $stable(io_rdata_o))
		else $error("read data moved without a read");

	// ==========
	// serial side and events
	a_idle_no_drive: assert property ((ss_n_i && ce_i) [*4] |-> miso_oe_n_o)
		else $error("output driven while deselected");
	a_freeze_hold: assert property (!ce_i |=> $stable({io_rdata_o, miso_o}))
		else $error("state moved while clock enable low");
	a_load_event_gap: assert property (tx_empty_event_o |=> !tx_empty_event_o [*4])
		else $error("load event not a single pulse");
	a_complete_gap: assert property (complete_event_o |=> !complete_event_o [*8])
		else $error("complete event faster than a byte");
endmodule

bind spi_byte_shift_port spi_byte_shift_port_monitor i_monitor (
	.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .bank_select_bit_i(bank_select_bit_i),
	.io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .ss_n_i(ss_n_i),
	.miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .tx_empty_event_o(tx_empty_event_o),
	.complete_event_o(complete_event_o));

// ---- sim/spi_peer_model.sv ----
`timescale 1ns/100ps

module spi_peer_model (
	// serial link
	output reg  sclk_o,
	output reg  mosi_o,
	output reg  ss_n_o,
	input  wire miso_i,
	input  wire miso_oe_n_i
);
	initial begin
		sclk_o = 1'b0;
		mosi_o = 1'b0;
		ss_n_o = 1'b1;
	end

	// ==========
	// one byte exchange, 320 ns serial clock
	task automatic xfer(input logic [7:0] tx, input logic pol, input logic pha,
			input logic lsb, output logic [7:0] rx);
		int i;
		int k;
		sclk_o = pol;
		#320 ss_n_o = 1'b0;
		#320;
		for (i = 0; i < 8; i++) begin
			k = lsb ? i : 7 - i;
			if (!pha) mosi_o = tx[k];
			#160 sclk_o = !pol;
			if (pha) mosi_o = tx[k];
			else rx[k] = miso_oe_n_i ? 1'bx : miso_i;
			#160 sclk_o = pol;
			if (pha) rx[k] = miso_oe_n_i ? 1'bx : miso_i;
		end
		#320 ss_n_o = 1'b1;
		// released line must not keep the last bit
		mosi_o = !mosi_o;
	endtask
endmodule

// ---- sim/spi_byte_shift_port_bench.sv ----
`timescale 1ns/100ps

module spi_byte_shift_port_bench;
	// ==========
	// stimulus and observation
	logic       clock_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       ce_i = 1'b1;
	logic       bank_select_bit_i = 1'b0;
	logic [7:0] io_addr_i = 8'h00;
	logic       io_wr_i = 1'b0;
	logic       io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	wire  [7:0] io_rdata_o;
	wire        sclk, mosi, ss_n, miso, miso_oe_n, load_ev, done_ev;
	int         miscompares = 0;
	int         num_checks = 0;
	int         ev_load = 0;
	int         ev_done = 0;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];

	always #20 clock_i = !clock_i;

	spi_byte_shift_port i_dut (.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i),
		.bank_select_bit_i(bank_select_bit_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .sclk_i(sclk),
		.mosi_i(mosi), .ss_n_i(ss_n), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
		.tx_empty_event_o(load_ev), .complete_event_o(done_ev));

	spi_peer_model i_peer (.sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n), .miso_i(miso),
		.miso_oe_n_i(miso_oe_n));

	always @(posedge clock_i) begin
		if (load_ev === 1'b1) ev_load++;
		if (done_ev === 1'b1) ev_done++;
	end

	// ==========
	// shared tasks
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task acc(input logic wr, input logic bank, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		io_wr_i <= wr;
		io_rd_i <= !wr;
		bank_select_bit_i <= bank;
		io_addr_i <= a;
		io_wdata_i <= d;
		@(posedge clock_i);
		io_wr_i <= 1'b0;
		io_rd_i <= 1'b0;
		bank_select_bit_i <= 1'b0;
		#1;
	endtask

	task rc(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, 1'b0, a, 8'h00);
		chk(io_rdata_o, exp);
	endtask

	// ==========
	// main sequence
	initial begin
		logic [7:0] b0, b1, p0, p1, r0, r1, cfg;
		int m;
		void'($urandom(32'h02a0aeda));
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		ce_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		ce_i <= 1'b1;
		rc(8'h29, 8'h00);
		rc(8'h2a, 8'h00);
		rc(8'h2b, 8'h10);
		acc(1'b0, 1'b1, 8'h29, 8'h00);
		chk(io_rdata_o, 8'h10);
		rc(8'h2c, 8'h00);
		acc(1'b1, 1'b0, 8'h2a, 8'hff);
		acc(1'b1, 1'b0, 8'h2b, 8'hf8);
		rc(8'h2a, 8'h00);
		rc(8'h2b, 8'h90);
		acc(1'b1, 1'b0, 8'h2b, 8'h00);
		// every order, phase and polarity; two bytes so the second one overruns
		for (m = 0; m < 8; m++) begin
			cfg = {m[2], 4'h0, m[1], m[0], 1'b1};
			b0 = $urandom;
			b1 = $urandom;
			p0 = $urandom;
			p1 = $urandom;
			acc(1'b1, 1'b0, 8'h2b, cfg);
			chk(8'(ev_load), 8'(2 * m));
			acc(1'b1, 1'b0, 8'h29, b0);
			acc(1'b1, 1'b0, 8'h29, b1);
			rc(8'h2b, cfg);
			txq = {b0, b1};
			rxq = {p0, p1};
			#13;
			i_peer.xfer(p0, m[0], m[1], m[2], r0);
			i_peer.xfer(p1, m[0], m[1], m[2], r1);
			chk(r0, txq.pop_front());
			chk(r1, txq.pop_front());
			rc(8'h2b, cfg | 8'h78);
			rc(8'h2b, cfg | 8'h18);
			rc(8'h2a, rxq.pop_front());
			rc(8'h2a, rxq.pop_front());
			rc(8'h2b, cfg | 8'h10);
			acc(1'b1, 1'b0, 8'h2b, 8'h00);
			rc(8'h2b, 8'h10);
			chk(8'(ev_load), 8'(2 * m + 2));
			chk(8'(ev_done), 8'(2 * m + 2));
		end
		give_verdict();
	end

	// run needs about 65 us; allow six times that
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule
